//--- verilog/ddr2_timing_pkg.sv
package ddr2_timing_pkg;
	localparam int ADDR_W = 13;
	localparam int BANKS = 4;
	localparam int PD_SLOW_BIT = 12;
	localparam int DQS_SE_BIT = 10;
	localparam int PRE_ALL_BIT = 10;
	localparam int WR_LSB = 9;
	localparam int WR_W = 3;
	localparam int AL_LSB = 3;
	localparam int AL_W = 3;
	localparam logic [1:0] MR_BA = 2'h0;
	localparam logic [1:0] EMR_BA = 2'h1;
	localparam logic [12:0] MR_RESET = 13'h0000;
	localparam logic [2:0] AL_RESET = 3'h0;
	localparam logic [3:0] FAST_EXIT_NCK = 4'h2;
	localparam logic [3:0] SLOW_EXIT_NCK = 4'h8;
	localparam logic [3:0] SLOW_EXIT_NCK_FAST_BIN = 4'h7;
	localparam int ODT_ON_NCK = 2;
	localparam int TRP_PS = 15000;
	localparam int LINK_PERIOD_PS = 160000;

	typedef enum {CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WRITE, CMD_READ} cmd_t;

	function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		cmd_t c;
		c = CMD_NOP;
		if (!cs_n) begin
			case ({ras_n, cas_n, we_n})
				3'h0: c = CMD_MRS;
				3'h1: c = CMD_REF;
				3'h2: c = CMD_PRE;
				3'h3: c = CMD_ACT;
				3'h4: c = CMD_WRITE;
				3'h5: c = CMD_READ;
				default: c = CMD_NOP;
			endcase
		end
		return c;
	endfunction

	// Round up to whole clock cycles
	function automatic int unsigned ns_to_nck(input int unsigned t_ps,
		input int unsigned period_ps);
		return (t_ps + period_ps - 1) / period_ps;
	endfunction

	// Programmed write recovery (code + 1) plus precharge cycles
	function automatic logic [4:0] dal_nck(input logic [2:0] wr_code, input logic [3:0] trp);
		return 5'(wr_code) + 5'h01 + 5'(trp);
	endfunction
endpackage

//--- verilog/level_sync.sv
`timescale 1ns/1ns
module level_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = d_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.stable;
endmodule

//--- verilog/ddr2_timing_core.sv
`timescale 1ns/1ns
module ddr2_timing_core
	import ddr2_timing_pkg::*;
#(
	parameter bit FAST_BIN = 1'b0,
	parameter int TRP_TIME_PS = TRP_PS,
	parameter int CK_PERIOD_PS = LINK_PERIOD_PS
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ck_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] ba_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic odt_i,
	output logic term_en_o,
	output logic read_ok_o,
	input wire logic early_read_clr_i,
	output logic early_read_o,
	output logic term_en_sys_o,
	output logic pd_slow_exit_o,
	output logic dqs_diff_o,
	output logic [AL_W-1:0] add_lat_o,
	output logic [4:0] wr_ap_delay_o
);
	localparam logic [3:0] TRP_NCK = 4'(ns_to_nck(TRP_TIME_PS, CK_PERIOD_PS));
	localparam logic [3:0] SLOW_BASE = FAST_BIN ? SLOW_EXIT_NCK_FAST_BIN : SLOW_EXIT_NCK;

	typedef struct packed {
		logic cke_q;
		logic [ODT_ON_NCK:0] odt_pipe;
		logic [ADDR_W-1:0] mr;
		logic [AL_W-1:0] al;
		logic [BANKS-1:0] open;
		logic apd;
		logic [3:0] exit_cnt;
		logic viol_tgl;
	} link_state_t;

	typedef struct packed {
		logic tgl_seen;
		logic early_flag;
		logic [4:0] dal;
	} sys_state_t;

	link_state_t q;
	link_state_t q_nxt;
	sys_state_t s_r;
	sys_state_t s_nxt;
	logic term_neg_r;
	logic [9:0] sync_in;
	logic [9:0] sync_out;
	logic cke_both;
	logic apd_exit;
	cmd_t cmd;

	assign cke_both = q.cke_q & cke_i;
	assign apd_exit = !q.cke_q && cke_i && q.apd;

	// Link side: everything counts real edges of the device clock
	always_comb begin
		logic [3:0] slow_nck;
		slow_nck = SLOW_BASE - {1'b0, q.al};
		q_nxt = q;
		cmd = cke_both ? decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i) : CMD_NOP;
		q_nxt.cke_q = cke_i;
		q_nxt.odt_pipe = {q.odt_pipe[ODT_ON_NCK-1:0], odt_i};
		case (cmd)
			CMD_MRS: begin
				if (ba_i == MR_BA) begin
					q_nxt.mr = addr_i;
				end else if (ba_i == EMR_BA) begin
					q_nxt.al = addr_i[AL_LSB +: AL_W];
				end
			end
			CMD_ACT: begin
				q_nxt.open[ba_i] = 1'b1;
			end
			CMD_PRE: begin
				if (addr_i[PRE_ALL_BIT]) begin
					q_nxt.open = '0;
				end else begin
					q_nxt.open[ba_i] = 1'b0;
				end
			end
			CMD_READ: begin
				if (q.exit_cnt != 4'h0) begin
					q_nxt.viol_tgl = ~q.viol_tgl;
				end
			end
			default: begin
			end
		endcase
		if (q.cke_q && !cke_i && |q.open) begin
			q_nxt.apd = 1'b1;
		end
		// Load N-1: first read may land on edge N after exit
		if (apd_exit) begin
			q_nxt.apd = 1'b0;
			q_nxt.exit_cnt = q.mr[PD_SLOW_BIT] ? slow_nck - 4'h1 : FAST_EXIT_NCK - 4'h1;
		end else if (q.exit_cnt != 4'h0) begin
			q_nxt.exit_cnt = q.exit_cnt - 4'h1;
		end
	end

	always_ff @(posedge ck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{cke_q: 1'b0, odt_pipe: '0, mr: MR_RESET, al: AL_RESET, open: '0,
				apd: 1'b0, exit_cnt: 4'h0, viol_tgl: 1'b0};
		end else begin
			q <= q_nxt;
		end
	end

	// Half-cycle lag keeps termination on until after the trailing edge
	always_ff @(negedge ck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			term_neg_r <= 1'b0;
		end else begin
			term_neg_r <= q.odt_pipe[ODT_ON_NCK];
		end
	end

	assign term_en_o = q.odt_pipe[ODT_ON_NCK] | term_neg_r;
	assign read_ok_o = (q.exit_cnt == 4'h0);

	// Write postamble length is not timed here, so an overlong one is harmless

	// Crossing to the system clock; mode fields are quasi-static
	assign sync_in = {q.viol_tgl, term_en_o, q.mr[PD_SLOW_BIT], q.mr[DQS_SE_BIT], q.al,
		q.mr[WR_LSB +: WR_W]};

	level_sync #(.W(10)) u_sync (
		.clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.d_i(sync_in),
		.q_o(sync_out)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.tgl_seen = sync_out[9];
		if (early_read_clr_i) begin
			s_nxt.early_flag = 1'b0;
		end
		if (sync_out[9] != s_r.tgl_seen) begin
			s_nxt.early_flag = 1'b1;
		end
		s_nxt.dal = dal_nck(sync_out[2:0], TRP_NCK);
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign early_read_o = s_r.early_flag;
	assign wr_ap_delay_o = s_r.dal;
	assign term_en_sys_o = sync_out[8];
	assign pd_slow_exit_o = sync_out[7];
	assign dqs_diff_o = ~sync_out[6];
	assign add_lat_o = sync_out[5:3];

	sequence s_odt_rise;
		!odt_i ##1 odt_i;
	endsequence

	sequence s_odt_fall;
		odt_i ##1 !odt_i;
	endsequence

	sequence s_fast_exit;
		apd_exit && !q.mr[PD_SLOW_BIT];
	endsequence

	sequence s_slow_exit;
		apd_exit && q.mr[PD_SLOW_BIT] && q.al == 3'h2 && !FAST_BIN;
	endsequence

	property p_odt_on;
		@(posedge ck_i) disable iff (!resetn_i)
		s_odt_rise |-> ##2 !term_en_o ##1 term_en_o;
	endproperty
	a_odt_on: assert property (p_odt_on) else $error("termination on at wrong edge");

	property p_odt_held;
		@(posedge ck_i) disable iff (!resetn_i)
		s_odt_fall |-> ##2 term_en_o ##1 !q.odt_pipe[ODT_ON_NCK];
	endproperty
	a_odt_held: assert property (p_odt_held) else $error("termination off at wrong edge");

	property p_odt_off_half;
		@(negedge ck_i) disable iff (!resetn_i)
		$fell(q.odt_pipe[ODT_ON_NCK]) |-> term_neg_r ##1 !term_neg_r;
	endproperty
	a_odt_off_half: assert property (p_odt_off_half) else $error("no half-cycle off lag");

	property p_fast_exit;
		@(posedge ck_i) disable iff (!resetn_i)
		s_fast_exit |=> !read_ok_o ##1 read_ok_o;
	endproperty
	a_fast_exit: assert property (p_fast_exit) else $error("fast exit count wrong");

	property p_slow_exit;
		@(posedge ck_i) disable iff (!resetn_i)
		s_slow_exit |=> !read_ok_o [*5] ##1 read_ok_o;
	endproperty
	a_slow_exit: assert property (p_slow_exit) else $error("slow exit count wrong");

	property p_early_read;
		@(posedge ck_i) disable iff (!resetn_i)
		(cmd == CMD_READ && !read_ok_o) |=> q.viol_tgl != $past(q.viol_tgl);
	endproperty
	a_early_read: assert property (p_early_read) else $error("early read not flagged");

	property p_mrs_capture;
		@(posedge ck_i) disable iff (!resetn_i)
		(cmd == CMD_MRS && ba_i == MR_BA) |=> q.mr == $past(addr_i);
	endproperty
	a_mrs_capture: assert property (p_mrs_capture) else $error("mode word not taken");

	property p_flag_set;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(sync_out[9] != s_r.tgl_seen) |=> early_read_o ##1 (early_read_o || $past(early_read_clr_i));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("early read flag lost");
endmodule

//--- verif/ddr2_ctrl_model.sv
`timescale 1ns/1ns
module ddr2_ctrl_model
	import ddr2_timing_pkg::*;
(
	input wire logic ck_i,
	input wire logic read_ok_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] rcw_o,
	output logic [1:0] ba_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic odt_o
);
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		rcw_o = 3'h7;
		ba_o = 2'h0;
		addr_o = '0;
		odt_o = 1'b0;
	end
	// Bench programs an additive latency of 2; bursts of four
	localparam int ADD_LAT = 2;
	localparam int BURST_LEN = 4;
	// Released bank and address lines show the inverse of the last value
	task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [ADDR_W-1:0] a);
		@(posedge ck_i);
		cs_n_o <= 1'b0;
		rcw_o <= rcw;
		ba_o <= b;
		addr_o <= a;
		@(posedge ck_i);
		cs_n_o <= 1'b1;
		rcw_o <= 3'h7;
		ba_o <= ~b;
		addr_o <= ~a;
	endtask
	task automatic cke_low();
		@(posedge ck_i);
		cke_o <= 1'b0;
		repeat (3) @(posedge ck_i);
	endtask
	task automatic cke_up();
		@(posedge ck_i);
		cke_o <= 1'b1;
	endtask
	task automatic set_odt(input logic v);
		@(posedge ck_i);
		odt_o <= v;
	endtask
	task automatic write_then_read(input logic [1:0] b);
		cmd(3'h4, b, '0);
		repeat (2) @(posedge ck_i);
		cmd(3'h5, b, '0);
	endtask
	task automatic close_bank(input logic [1:0] b);
		repeat (ADD_LAT + BURST_LEN / 2) @(posedge ck_i);
		cmd(3'h2, b, '0);
	endtask
	task automatic read_when_ok();
		for (int i = 0; i < 20 && !read_ok_i; i++) @(posedge ck_i);
		cmd(3'h5, 2'h0, '0);
	endtask
endmodule

//--- verif/ddr2_timing_core_tb_top.sv
`timescale 1ns/1ns
module ddr2_timing_core_tb_top
	import ddr2_timing_pkg::*;
;
	logic sys_clk_i = 1'b0, ck_i = 1'b0, resetn_i = 1'b0, clr = 1'b0;
	logic cke, cs_n, odt, term_en, read_ok, early, term_sys, pd_slow, dqs_diff;
	logic [2:0] rcw, al;
	logic [1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [4:0] wr_ap;
	int fail_count = 0, total_checks = 0;
	ddr2_timing_core dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ck_i(ck_i), .cke_i(cke),
		.cs_n_i(cs_n), .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]), .ba_i(ba),
		.addr_i(addr), .odt_i(odt), .term_en_o(term_en), .read_ok_o(read_ok),
		.early_read_clr_i(clr), .early_read_o(early), .term_en_sys_o(term_sys),
		.pd_slow_exit_o(pd_slow), .dqs_diff_o(dqs_diff), .add_lat_o(al), .wr_ap_delay_o(wr_ap));
	ddr2_ctrl_model ctrl (.ck_i(ck_i), .read_ok_i(read_ok), .cke_o(cke), .cs_n_o(cs_n),
		.rcw_o(rcw), .ba_o(ba), .addr_o(addr), .odt_o(odt));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	initial begin
		#7;
		forever #80 ck_i = ~ck_i;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_mode(input logic [ADDR_W-1:0] mr, input logic [7:0] slow,
		input logic [7:0] diff, input logic [7:0] wr);
		ctrl.cmd(3'h0, MR_BA, mr);
		ctrl.cmd(3'h0, EMR_BA, 13'h0010);
		repeat (8) @(posedge sys_clk_i);
		check(8'(pd_slow), slow);
		check(8'(dqs_diff), diff);
		check(8'(al), 8'h02);
		check(8'(wr_ap), wr + 8'((TRP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS));
		$display("mode test done");
	endtask
	task automatic t_odt();
		ctrl.set_odt(1'b1);
		repeat (2) @(posedge ck_i);
		#1 check(8'(term_en), 8'h00);
		@(posedge ck_i);
		#1 check(8'(term_en), 8'h01);
		repeat (4) @(posedge sys_clk_i);
		check(8'(term_sys), 8'h01);
		ctrl.set_odt(1'b0);
		repeat (3) @(posedge ck_i);
		#1 check(8'(term_en), 8'h01);
		@(negedge ck_i);
		#1 check(8'(term_en), 8'h00);
		$display("termination test done");
	endtask
	task automatic t_exit(input int n, input logic early_rd);
		int lows = 0;
		ctrl.cmd(3'h3, 2'h1, 13'h0000);
		ctrl.cke_low();
		ctrl.cke_up();
		@(posedge ck_i);
		fork
			for (int k = 0; k < 10; k++) begin
				@(negedge ck_i);
				if (read_ok !== 1'b1) lows++;
			end
			if (early_rd) ctrl.cmd(3'h5, 2'h1, 13'h0000);
		join
		check(8'(lows), 8'(n - 1));
		if (!early_rd) ctrl.read_when_ok();
		repeat (8) @(posedge sys_clk_i);
		check(8'(early), 8'(early_rd));
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		check(8'(early), 8'h00);
		$display("exit test done");
	endtask
	task automatic t_ppd();
		int lows = 0;
		ctrl.write_then_read(2'h1);
		ctrl.close_bank(2'h1);
		ctrl.cmd(3'h1, 2'h0, '0);
		ctrl.cke_low();
		ctrl.cke_up();
		for (int k = 0; k < 4; k++) begin
			@(negedge ck_i);
			if (read_ok !== 1'b1) lows++;
		end
		check(8'(lows), 8'h00);
		repeat (8) @(posedge sys_clk_i);
		check(8'(early), 8'h00);
		$display("precharge power-down test done");
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		#1 check(8'(term_en), 8'h00);
		check(8'(read_ok), 8'h01);
		check(8'(dqs_diff), 8'h01);
		repeat (4) @(posedge ck_i);
		t_mode(13'h1200, 8'h01, 8'h01, 8'h02);
		t_odt();
		t_exit(8 - 2, 1'b1);
		t_mode(13'h0e00, 8'h00, 8'h00, 8'h08);
		t_exit(2, 1'b0);
		t_ppd();
		give_verdict();
	end
endmodule
